// [verilog/uart_pkg.sv]
// shared constants, register map and state types for the dual uart
package uart_pkg;
    localparam int NCH = 2;
    localparam logic [6:0] FIFO_DEPTH = 7'h40;
    // register byte offsets inside one channel window
    localparam int CH_BIT = 6;
    localparam logic [5:0] R_DATA = 6'h00;
    localparam logic [5:0] R_IER = 6'h04;
    localparam logic [5:0] R_STS = 6'h08;
    localparam logic [5:0] R_LCR = 6'h0C;
    localparam logic [5:0] R_MCR = 6'h10;
    localparam logic [5:0] R_MSR = 6'h14;
    localparam logic [5:0] R_DIV = 6'h18;
    localparam logic [5:0] R_FEATURE_CONTROL_REG = 6'h1C;
    localparam logic [5:0] R_EFR = 6'h20;
    localparam logic [5:0] R_XON = 6'h24;
    localparam logic [5:0] R_XOFF = 6'h28;
    localparam logic [5:0] R_TRG = 6'h2C;
    localparam logic [5:0] R_LEVEL = 6'h30;
    // field positions
    localparam int LCR_PRE4 = 0;
    localparam int LCR_OVS8 = 1;
    localparam int MCR_DTR = 0;
    localparam int MCR_RTS = 1;
    localparam int MCR_OUT2 = 3;
    localparam int MCR_IR = 6;
    localparam int FEATURE_CONTROL_REG_IRINV = 2;
    localparam int FEATURE_CONTROL_REG_DIR = 3;
    localparam int EFR_SWFC = 3;
    localparam int EFR_ARTS = 6;
    localparam int EFR_ACTS = 7;
    localparam int EV_RX = 0;
    localparam int EV_TXE = 1;
    localparam int EV_OVR = 2;
    localparam int EV_FRM = 3;
    localparam int EV_XOFF = 5;
    localparam int EV_CTS = 7;
    // reset values
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [7:0] XON_RST = 8'h11;
    localparam logic [7:0] XOFF_RST = 8'h13;
    localparam logic [6:0] TRG_RST = 7'h20;
    // timing
    localparam int CLK_NS = 20;
    localparam int RST_MIN_NS = 40;
    localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] IR_W16 = 4'h3;
    localparam logic [3:0] IR_W8 = 4'h1;

    typedef enum logic [1:0] {T_IDLE, T_START, T_DATA, T_STOP} tx_state_type;
    typedef enum logic [1:0] {R_IDLE, R_START, R_BITS, R_STOP} rx_state_type;

    typedef struct packed {
        logic [7:0] irq_enable_reg, sts;
        logic [1:0] lcr;
        logic [7:0] modem_control_reg;
        logic [15:0] div;
        logic [3:0] feature_control_reg;
        logic [7:0] enhanced_feature_reg, xon, xoff;
        logic [6:0] rxtrg, txtrg;
        logic [5:0] twp, trp, rwp, rrp;
        logic [6:0] tcnt, rcnt;
        logic [1:0] pre;
        logic [15:0] bdc;
        logic tick;
        tx_state_type txs;
        logic [3:0] tsc, tbit;
        logic [7:0] tsh;
        rx_state_type rxs;
        logic [3:0] rsc, rbit, irs;
        logic [7:0] rsh;
        logic paused, hold, cts_q;
        logic txd, rts_n, dtr_n, op2_n, irq, irq_oe_n;
    } chan_type;

    typedef struct packed {
        chan_type [NCH-1:0] ch;
        logic [31:0] prdata;
        logic pready, pslverr;
    } state_type;
endpackage : uart_pkg

// [verilog/dual_uart.sv]
// two-channel uart with apb registers, flow and rs-485 direction control
// Notes on behaviour
// (RQ1) far sender idles the non-infrared receive line high.
// (RQ2) infrared receive idles low; optional input inversion before decoder.
// (RQ3) host sets rts before enabling automatic rts flow control.
// (RQ4) automatic cts pacing of transmit, with its own interrupt enable.
// (RQ5) dsr, carrier and ring inputs are readable only, no effect.
// (RQ6) out2 set: interrupt driven, user out2 pin low.
// (RQ7) out2 clear: interrupt high impedance, user out2 pin high.
// (RQ8) reset returns all registers and outputs to defaults.
// (RQ9) during reset transmit stays high and receive is ignored.
// (RQ10) infrared mode encodes transmit, idling low; else idles high.
// (RQ11) two channels, each with its own full register set.
// (RQ12) 64-byte transmit and receive buffers, triggers and level counters.
// (RQ13) prescaler divides clock by one or four before divisor.
// (RQ14) receiver oversamples at eight or sixteen per bit.
// (RQ15) direction goes to receive after last stop bit leaves.
// (RQ16) direction returns to transmit once a byte is loaded.
// (RQ17) direction control off after reset, enabled by feature bit.
// (RQ18) direction pin high for receive, low for transmit.
// (RQ19) automatic rts/cts with hysteresis and xon/xoff flow control.
`timescale 1ns/1ps
module dual_uart
    import uart_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic chan_a_serial_in,
    output logic chan_a_serial_out,
    output logic chan_a_request_send_n_out,
    input wire logic chan_a_clear_send_n_in,
    output logic chan_a_terminal_ready_n_out,
    input wire logic chan_a_set_ready_n_in,
    input wire logic chan_a_carrier_n_in,
    input wire logic chan_a_ring_n_in,
    output logic chan_a_user_out2_n_out,
    output logic chan_a_irq_out,
    output logic chan_a_irq_oe_n_out,
    input wire logic chan_b_serial_in,
    output logic chan_b_serial_out,
    output logic chan_b_request_send_n_out,
    input wire logic chan_b_clear_send_n_in,
    output logic chan_b_terminal_ready_n_out,
    input wire logic chan_b_set_ready_n_in,
    input wire logic chan_b_carrier_n_in,
    input wire logic chan_b_ring_n_in,
    output logic chan_b_user_out2_n_out,
    output logic chan_b_irq_out,
    output logic chan_b_irq_oe_n_out
);
    state_type r, n;
    logic [7:0] txm [NCH][64];
    logic [7:0] rxm [NCH][64];
    logic [NCH-1:0] tpush, rpush;
    logic [7:0] rbyte [NCH];
    logic [NCH-1:0] sin, cts_n, dsr_n, cd_n, ri_n;
    // pins gathered per channel index
    assign sin = {chan_b_serial_in, chan_a_serial_in};
    assign cts_n = {chan_b_clear_send_n_in, chan_a_clear_send_n_in};
    assign dsr_n = {chan_b_set_ready_n_in, chan_a_set_ready_n_in};
    assign cd_n = {chan_b_carrier_n_in, chan_a_carrier_n_in};
    assign ri_n = {chan_b_ring_n_in, chan_a_ring_n_in};
    // whole next state: bus slave, both channels, reset
    always_comb begin
        logic setup, done, ok, wr, rd, ln, tl;
        logic tpop, rpop, tp, rp;
        logic [5:0] a;
        logic [3:0] om, hm;
        logic [7:0] ev, wm;
        logic [6:0] hy;
        logic [31:0] rdat;
        chan_type s;
        n = r;
        setup = psel_in && !penable_in;
        done = psel_in && penable_in && r.pready;
        a = paddr_in[5:0];
        ok = !paddr_in[7] && paddr_in[1:0] == 2'h0 && a <= R_LEVEL;
        wr = 1'b0;
        rd = 1'b0;
        ln = 1'b1;
        tl = 1'b1;
        tpop = 1'b0;
        rpop = 1'b0;
        tp = 1'b0;
        rp = 1'b0;
        om = 4'hF;
        hm = 4'h7;
        ev = 8'h00;
        wm = 8'h00;
        hy = 7'h00;
        rdat = 32'h0;
        tpush = '0;
        rpush = '0;
        rbyte = '{default: 8'h00};
        s = r.ch[paddr_in[CH_BIT]];
        // read data is caught in setup, ready follows one cycle on
        unique case (a)
            R_DATA: rdat = {24'h0, rxm[paddr_in[CH_BIT]][s.rrp]};
            R_IER: rdat = {24'h0, s.irq_enable_reg};
            R_STS: rdat = {24'h0, s.sts};
            R_LCR: rdat = {30'h0, s.lcr};
            R_MCR: rdat = {24'h0, s.modem_control_reg};
            R_MSR: rdat = {27'h0, s.paused, ~ri_n[paddr_in[CH_BIT]],
                ~cd_n[paddr_in[CH_BIT]], ~dsr_n[paddr_in[CH_BIT]],
                ~cts_n[paddr_in[CH_BIT]]}; // RQ5
            R_DIV: rdat = {16'h0, s.div};
            R_FEATURE_CONTROL_REG: rdat = {28'h0, s.feature_control_reg};
            R_EFR: rdat = {24'h0, s.enhanced_feature_reg};
            R_XON: rdat = {24'h0, s.xon};
            R_XOFF: rdat = {24'h0, s.xoff};
            R_TRG: rdat = {17'h0, s.txtrg, 1'b0, s.rxtrg};
            R_LEVEL: rdat = {17'h0, s.tcnt, 1'b0, s.rcnt}; // RQ12
            default: rdat = 32'h0;
        endcase
        n.pready = setup;
        n.pslverr = setup && !ok;
        n.prdata = (setup && ok) ? rdat : 32'h0;
        for (int c = 0; c < NCH; c++) begin // RQ11
            s = r.ch[c];
            wr = done && pwrite_in && ok && paddr_in[CH_BIT] == c[0];
            rd = done && !pwrite_in && ok && paddr_in[CH_BIT] == c[0];
            ev = 8'h00;
            wm = (wr && a == R_STS) ? pwdata_in[7:0] : 8'h00;
            tpop = 1'b0;
            rpop = rd && a == R_DATA && s.rcnt != 7'h0;
            tp = wr && a == R_DATA && s.tcnt != FIFO_DEPTH;
            rp = 1'b0;
            tpush[c] = tp;
            // software writes, other than data and status
            if (wr) begin
                unique case (a)
                    R_IER: n.ch[c].irq_enable_reg = pwdata_in[7:0];
                    R_LCR: n.ch[c].lcr = pwdata_in[1:0];
                    R_MCR: n.ch[c].modem_control_reg = pwdata_in[7:0];
                    R_DIV: n.ch[c].div = pwdata_in[15:0];
                    R_FEATURE_CONTROL_REG: n.ch[c].feature_control_reg = pwdata_in[3:0]; // RQ17
                    R_EFR: n.ch[c].enhanced_feature_reg = pwdata_in[7:0];
                    R_XON: n.ch[c].xon = pwdata_in[7:0];
                    R_XOFF: n.ch[c].xoff = pwdata_in[7:0];
                    R_TRG: begin
                        n.ch[c].rxtrg = pwdata_in[6:0];
                        n.ch[c].txtrg = pwdata_in[14:8];
                    end
                    default: ;
                endcase
            end
            // prescale by 1 or 4, then divisor; zero divisor acts as one
            n.ch[c].tick = 1'b0;
            if (s.pre == (s.lcr[LCR_PRE4] ? 2'h3 : 2'h0)) begin // RQ13
                n.ch[c].pre = 2'h0;
                if (s.bdc + 16'h1 >= s.div) begin
                    n.ch[c].bdc = 16'h0;
                    n.ch[c].tick = 1'b1;
                end else begin
                    n.ch[c].bdc = s.bdc + 16'h1;
                end
            end else begin
                n.ch[c].pre = s.pre + 2'h1;
            end
            om = s.lcr[LCR_OVS8] ? 4'h7 : 4'hF; // RQ14
            hm = s.lcr[LCR_OVS8] ? 4'h3 : 4'h7;
            // stretch ir pulses to a bit: mid-bit sampling keeps them
            if (s.modem_control_reg[MCR_IR]) begin
                if (sin[c] ^ s.feature_control_reg[FEATURE_CONTROL_REG_IRINV]) begin // RQ2
                    n.ch[c].irs = om;
                end else if (s.tick && s.irs != 4'h0) begin
                    n.ch[c].irs = s.irs - 4'h1;
                end
                ln = !((sin[c] ^ s.feature_control_reg[FEATURE_CONTROL_REG_IRINV]) || s.irs != 4'h0);
            end else begin
                ln = sin[c]; // RQ1
            end
            // transmitter; cts high with auto cts on, or a received xoff, holds the next start
            if (s.tick) begin
                if (s.txs == T_IDLE) begin
                    if (s.tcnt != 7'h0 && !s.paused &&
                        !(s.enhanced_feature_reg[EFR_ACTS] && cts_n[c])) begin // RQ4
                        n.ch[c].tsh = txm[c][s.trp];
                        n.ch[c].txs = T_START;
                        n.ch[c].tsc = 4'h0;
                        tpop = 1'b1;
                    end
                end else if (s.tsc == om) begin
                    n.ch[c].tsc = 4'h0;
                    unique case (s.txs)
                        T_START: begin
                            n.ch[c].txs = T_DATA;
                            n.ch[c].tbit = 4'h0;
                        end
                        T_DATA: begin
                            n.ch[c].tsh = {1'b0, s.tsh[7:1]};
                            n.ch[c].tbit = s.tbit + 4'h1;
                            if (s.tbit == 4'h7) begin
                                n.ch[c].txs = T_STOP;
                            end
                        end
                        default: n.ch[c].txs = T_IDLE;
                    endcase
                end else begin
                    n.ch[c].tsc = s.tsc + 4'h1;
                end
            end
            if (tpop && s.tcnt - 7'h1 <= s.txtrg) begin
                ev[EV_TXE] = 1'b1;
            end
            tl = (s.txs == T_START) ? 1'b0 :
                (s.txs == T_DATA) ? s.tsh[0] : 1'b1;
            // infrared: short high pulse for each zero bit, low at rest
            n.ch[c].txd = s.modem_control_reg[MCR_IR] ? (!tl && s.tsc <
                (s.lcr[LCR_OVS8] ? IR_W8 : IR_W16)) : tl; // RQ10
            // receiver, sampled on the oversampling tick
            if (s.tick) begin
                unique case (s.rxs)
                    R_IDLE: begin
                        if (!ln) begin
                            n.ch[c].rxs = R_START;
                            n.ch[c].rsc = 4'h0;
                        end
                    end
                    R_START: begin
                        n.ch[c].rsc = s.rsc + 4'h1;
                        if (s.rsc == hm) begin
                            n.ch[c].rsc = 4'h0;
                            n.ch[c].rbit = 4'h0;
                            n.ch[c].rxs = ln ? R_IDLE : R_BITS;
                        end
                    end
                    R_BITS: begin
                        n.ch[c].rsc = s.rsc + 4'h1;
                        if (s.rsc == om) begin
                            n.ch[c].rsc = 4'h0;
                            n.ch[c].rsh = {ln, s.rsh[7:1]};
                            n.ch[c].rbit = s.rbit + 4'h1;
                            if (s.rbit == 4'h7) begin
                                n.ch[c].rxs = R_STOP;
                            end
                        end
                    end
                    R_STOP: begin
                        n.ch[c].rsc = s.rsc + 4'h1;
                        if (s.rsc == om) begin
                            n.ch[c].rxs = R_IDLE;
                            if (!ln) begin
                                ev[EV_FRM] = 1'b1;
                            end else if (s.enhanced_feature_reg[EFR_SWFC] &&
                                s.rsh == s.xoff) begin // RQ19
                                n.ch[c].paused = 1'b1;
                                ev[EV_XOFF] = 1'b1;
                            end else if (s.enhanced_feature_reg[EFR_SWFC] &&
                                s.rsh == s.xon) begin
                                n.ch[c].paused = 1'b0;
                            end else if (s.rcnt == FIFO_DEPTH) begin
                                ev[EV_OVR] = 1'b1;
                            end else begin
                                rp = 1'b1;
                            end
                        end
                    end
                endcase
            end
            rpush[c] = rp;
            rbyte[c] = s.rsh;
            if (rp && s.rcnt + 7'h1 >= s.rxtrg) begin
                ev[EV_RX] = 1'b1;
            end
            // buffer pointers and level counters
            n.ch[c].twp = s.twp + {5'h0, tp};
            n.ch[c].trp = s.trp + {5'h0, tpop};
            n.ch[c].tcnt = s.tcnt + {6'h0, tp} - {6'h0, tpop}; // RQ12
            n.ch[c].rwp = s.rwp + {5'h0, rp};
            n.ch[c].rrp = s.rrp + {5'h0, rpop};
            n.ch[c].rcnt = s.rcnt + {6'h0, rp} - {6'h0, rpop};
            // cts edge event
            n.ch[c].cts_q = cts_n[c];
            if (s.cts_q != cts_n[c]) begin
                ev[EV_CTS] = 1'b1;
            end
            // auto rts with hysteresis below the receive trigger
            hy = (s.feature_control_reg[1:0] == 2'h0) ? 7'h0 : 7'h2 << s.feature_control_reg[1:0];
            if (s.rcnt >= s.rxtrg) begin
                n.ch[c].hold = 1'b1; // RQ19
            end else if (s.rcnt + hy <= s.rxtrg) begin
                n.ch[c].hold = 1'b0;
            end
            if (s.feature_control_reg[FEATURE_CONTROL_REG_DIR]) begin // high once the stop bit is out
                n.ch[c].rts_n = s.txs == T_IDLE &&
                    s.tcnt == 7'h0; // RQ15 RQ16 RQ18
            end else begin
                n.ch[c].rts_n = !(s.modem_control_reg[MCR_RTS] &&
                    !(s.enhanced_feature_reg[EFR_ARTS] && s.hold)); // RQ3
            end
            // set wins over a write-one clear in the same cycle
            n.ch[c].sts = (s.sts & ~wm) | ev;
            n.ch[c].dtr_n = !s.modem_control_reg[MCR_DTR];
            n.ch[c].op2_n = !s.modem_control_reg[MCR_OUT2]; // RQ6 RQ7
            n.ch[c].irq_oe_n = !s.modem_control_reg[MCR_OUT2];
            n.ch[c].irq = s.modem_control_reg[MCR_OUT2] && |(s.sts & s.irq_enable_reg);
        end
        // synchronous reset: defaults, line idle high, receiver ignored
        if (sys_rst_in) begin // RQ8 RQ9
            n = '0;
            tpush = '0;
            rpush = '0;
            for (int c = 0; c < NCH; c++) begin
                n.ch[c].div = DIV_RST;
                n.ch[c].xon = XON_RST;
                n.ch[c].xoff = XOFF_RST;
                n.ch[c].rxtrg = TRG_RST;
                n.ch[c].txtrg = TRG_RST;
                n.ch[c].cts_q = 1'b1;
                n.ch[c].txd = 1'b1;
                n.ch[c].rts_n = 1'b1;
                n.ch[c].dtr_n = 1'b1;
                n.ch[c].op2_n = 1'b1;
                n.ch[c].irq_oe_n = 1'b1;
            end
        end
    end
    // state register; reset is already folded into n
    always_ff @(posedge clk_in) begin
        r <= n;
    end
    // buffer storage lives outside the state record
    always_ff @(posedge clk_in) begin
        for (int c = 0; c < NCH; c++) begin
            if (tpush[c]) begin
                txm[c][r.ch[c].twp] <= pwdata_in[7:0];
            end
            if (rpush[c]) begin
                rxm[c][r.ch[c].rwp] <= rbyte[c];
            end
        end
    end
    // every output straight from the state register
    assign prdata_out = r.prdata;
    assign pready_out = r.pready;
    assign pslverr_out = r.pslverr;
    assign chan_a_serial_out = r.ch[0].txd;
    assign chan_a_request_send_n_out = r.ch[0].rts_n;
    assign chan_a_terminal_ready_n_out = r.ch[0].dtr_n;
    assign chan_a_user_out2_n_out = r.ch[0].op2_n;
    assign chan_a_irq_out = r.ch[0].irq;
    assign chan_a_irq_oe_n_out = r.ch[0].irq_oe_n;
    assign chan_b_serial_out = r.ch[1].txd;
    assign chan_b_request_send_n_out = r.ch[1].rts_n;
    assign chan_b_terminal_ready_n_out = r.ch[1].dtr_n;
    assign chan_b_user_out2_n_out = r.ch[1].op2_n;
    assign chan_b_irq_out = r.ch[1].irq;
    assign chan_b_irq_oe_n_out = r.ch[1].irq_oe_n;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    a_reset_line: assert property (disable iff (1'b0) // RQ9
        sys_rst_in |=> chan_a_serial_out && chan_b_serial_out)
        else $error("serial out not high after reset");
    a_reset_state: assert property (disable iff (1'b0) // RQ8
        sys_rst_in |=> r.ch[0].sts == 8'h00 && !chan_a_irq_out
        && r.ch[1].tcnt == 7'h0 && r.ch[0].div == DIV_RST)
        else $error("state not at default after reset");
    a_dir_off: assert property (disable iff (1'b0) // RQ17
        sys_rst_in |=> !r.ch[0].feature_control_reg[FEATURE_CONTROL_REG_DIR] && !r.ch[1].feature_control_reg[FEATURE_CONTROL_REG_DIR])
        else $error("direction control enabled after reset");
    a_out2_on: assert property (r.ch[0].modem_control_reg[MCR_OUT2] |=> // RQ6
        !chan_a_user_out2_n_out && !chan_a_irq_oe_n_out)
        else $error("out2 set but pins not driven");
    a_out2_off: assert property (!r.ch[1].modem_control_reg[MCR_OUT2] |=> // RQ7
        chan_b_user_out2_n_out && chan_b_irq_oe_n_out && !chan_b_irq_out)
        else $error("out2 clear but irq still driven");
    a_dir_recv: assert property (r.ch[0].feature_control_reg[FEATURE_CONTROL_REG_DIR] && // RQ15
        r.ch[0].txs == T_IDLE && r.ch[0].tcnt == 7'h0
        |=> chan_a_request_send_n_out)
        else $error("direction not receive when idle");
    a_dir_xmit: assert property (r.ch[0].feature_control_reg[FEATURE_CONTROL_REG_DIR] && // RQ16
        (r.ch[0].tcnt != 7'h0 || r.ch[0].txs != T_IDLE)
        |=> !chan_a_request_send_n_out)
        else $error("direction not transmit with data queued");
    a_cts_pace: assert property (r.ch[0].enhanced_feature_reg[EFR_ACTS] && // RQ4
        chan_a_clear_send_n_in && r.ch[0].txs == T_IDLE
        |=> r.ch[0].txs == T_IDLE)
        else $error("character started while cts deasserted");
    a_ir_idle: assert property (r.ch[1].modem_control_reg[MCR_IR] && // RQ10
        r.ch[1].txs == T_IDLE |=> !chan_b_serial_out)
        else $error("infrared transmit not low at rest");
    a_fifo_bound: assert property (r.ch[0].tcnt <= FIFO_DEPTH // RQ12
        && r.ch[0].rcnt <= FIFO_DEPTH)
        else $error("buffer level above depth");
    c_tx_start: cover property (r.ch[0].txs == T_IDLE ##1
        r.ch[0].txs == T_START);
    c_rx_byte: cover property (rpush[1]);
    c_irq_up: cover property (!chan_a_irq_out ##1 chan_a_irq_out);
    c_dir_flip: cover property (!chan_a_request_send_n_out
        && r.ch[0].feature_control_reg[FEATURE_CONTROL_REG_DIR] ##1 chan_a_request_send_n_out);
endmodule : dual_uart

// [testbench/uart_line_partner.sv]
// far-side serial device: idle sender and frame receiver
`timescale 1ns/1ps
module uart_line_partner #(
    parameter int BIT_CLKS = 16
) (
    input wire logic clk_in,
    input wire logic line_in,
    output logic line_out,
    output logic [7:0] byte_out,
    output logic got_out
);
    // this side never sends, so its line only idles
    assign line_out = 1'b1;
    // sample mid-bit, well away from the launching edges
    initial begin
        got_out = 1'b0;
        byte_out = 8'h00;
        forever begin
            @(negedge line_in);
            repeat (BIT_CLKS / 2) @(posedge clk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CLKS) @(posedge clk_in);
                byte_out[i] = line_in;
            end
            repeat (BIT_CLKS) @(posedge clk_in);
            got_out <= line_in; // bad stop bit drops the byte
            @(posedge clk_in);
            got_out <= 1'b0;
        end
    end
endmodule : uart_line_partner

// [testbench/tb_uart_channel_modem_rs485_dir.sv]
// self-checking bench for the dual uart, channel a on the line
`timescale 1ns/1ps
module tb_uart_channel_modem_rs485_dir;
    import uart_pkg::*;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, psel_in = 1'b0;
    logic penable_in = 1'b0, pwrite_in = 1'b0, chan_a_serial_in, got;
    logic [7:0] paddr_in = 8'h00, gbyte, d;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic pready_out, pslverr_out, err;
    logic chan_a_serial_out, chan_a_request_send_n_out, chan_a_irq_out;
    logic chan_a_terminal_ready_n_out, chan_a_user_out2_n_out;
    logic chan_b_serial_out, chan_b_request_send_n_out, chan_b_irq_out;
    logic chan_b_terminal_ready_n_out, chan_b_user_out2_n_out;
    logic chan_a_irq_oe_n_out, chan_b_irq_oe_n_out;
    logic [5:0] mdm = 6'h3F;
    logic cts_n = 1'b0;
    logic [7:0] exp_q[$];
    int n_errors = 0, cmp_count = 0, seed = 32'h191C;
    dual_uart DUT (.clk_in, .sys_rst_in, .paddr_in, .psel_in, .penable_in,
        .pwrite_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
        .chan_a_serial_in, .chan_a_serial_out, .chan_a_request_send_n_out,
        .chan_a_clear_send_n_in(cts_n), .chan_a_terminal_ready_n_out,
        .chan_a_set_ready_n_in(mdm[0]), .chan_a_carrier_n_in(mdm[1]),
        .chan_a_ring_n_in(mdm[2]), .chan_a_user_out2_n_out, .chan_a_irq_out,
        .chan_a_irq_oe_n_out, .chan_b_serial_in(1'b1), .chan_b_serial_out,
        .chan_b_request_send_n_out, .chan_b_clear_send_n_in(1'b0),
        .chan_b_terminal_ready_n_out, .chan_b_set_ready_n_in(mdm[3]),
        .chan_b_carrier_n_in(mdm[4]), .chan_b_ring_n_in(mdm[5]),
        .chan_b_user_out2_n_out, .chan_b_irq_out, .chan_b_irq_oe_n_out);
    uart_line_partner #(.BIT_CLKS(16)) far (.clk_in,
        .line_in(chan_a_serial_out), .line_out(chan_a_serial_in),
        .byte_out(gbyte), .got_out(got));
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    // modem inputs wander; they must not disturb anything
    always @(posedge clk_in) begin
        mdm <= 6'($random(seed));
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] v);
        int k;
        k = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= v;
        @(posedge clk_in);
        penable_in <= 1'b1;
        // hold until pready is seen high at a rising edge
        do begin
            @(posedge clk_in);
            k++;
        end while (pready_out !== 1'b1 && k < 40);
        chk(k < 40, 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    task automatic wait_q(input int n);
        int k;
        k = 0;
        while (exp_q.size() > n && k < 3000) begin
            @(negedge clk_in);
            k++;
        end
    endtask : wait_q
    task automatic step(input int n);
        repeat (n) @(negedge clk_in);
    endtask : step
    task automatic finish_test;
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    // oldest queued byte against each frame the partner decodes
    always @(posedge clk_in) begin
        if (got === 1'b1) begin
            chk(exp_q.size() > 0, 1'b1);
            if (exp_q.size() > 0) chk(gbyte, exp_q.pop_front());
        end
    end
    // about 10000 clocks, several times what the tests need
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
    initial begin
        repeat (3) @(posedge clk_in);
        chk(chan_a_serial_out, 1'b1);
        repeat (2) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        step(1);
        chk({chan_a_request_send_n_out, chan_a_user_out2_n_out,
            chan_a_irq_oe_n_out, chan_a_irq_out, chan_a_serial_out},
            5'b11101);
        $display("test reset done");
        // direction control still off: pin ignores the frame
        d = 8'($random(seed));
        exp_q.push_back(d);
        apb(1'b1, {2'b00, R_DATA}, {24'h0, d});
        step(40);
        chk(chan_a_request_send_n_out, 1'b1);
        wait_q(0);
        apb(1'b1, {2'b00, R_FEATURE_CONTROL_REG}, 32'h8);
        step(12); // last stop bit may still be leaving
        chk(chan_a_request_send_n_out, 1'b1);
        // two queued bytes: pin must hold across the gap
        for (int i = 0; i < 2; i++) begin
            d = 8'($random(seed));
            exp_q.push_back(d);
            apb(1'b1, {2'b00, R_DATA}, {24'h0, d});
        end
        step(2);
        chk(chan_a_request_send_n_out, 1'b0);
        wait_q(1);
        chk(chan_a_request_send_n_out, 1'b0);
        wait_q(0);
        chk(chan_a_request_send_n_out, 1'b0);
        step(12);
        chk(chan_a_request_send_n_out, 1'b1);
        $display("test direction done");
        // auto cts holds a queued byte; rts is set before auto rts
        apb(1'b1, {2'b00, R_FEATURE_CONTROL_REG}, 32'h0);
        apb(1'b1, {2'b00, R_MCR}, 32'h2);
        apb(1'b1, {2'b00, R_EFR}, 32'hC0);
        cts_n <= 1'b1;
        d = 8'($random(seed));
        exp_q.push_back(d);
        apb(1'b1, {2'b00, R_DATA}, {24'h0, d});
        step(200);
        chk({chan_a_request_send_n_out, chan_a_serial_out}, 2'b01);
        @(posedge clk_in);
        cts_n <= 1'b0;
        wait_q(0);
        chk(exp_q.size() == 0, 1'b1);
        $display("test flow done");
        // tx-empty status raised, masked, unmasked, cleared
        apb(1'b1, {2'b00, R_MCR}, 32'h8);
        step(2);
        chk({chan_a_irq_oe_n_out, chan_a_user_out2_n_out, chan_a_irq_out},
            3'b000);
        apb(1'b1, {2'b00, R_IER}, 32'h2);
        step(2);
        chk(chan_a_irq_out, 1'b1);
        apb(1'b1, {2'b00, R_STS}, 32'h2);
        step(2);
        chk(chan_a_irq_out, 1'b0);
        apb(1'b0, {2'b00, R_STS}, 32'h0);
        chk(rd[1], 1'b0);
        apb(1'b1, {2'b00, R_MCR}, 32'h0);
        step(2);
        chk({chan_a_irq_oe_n_out, chan_a_user_out2_n_out, chan_a_irq_out},
            3'b110);
        apb(1'b1, {2'b01, R_MCR}, 32'h48);
        step(2);
        chk({chan_b_user_out2_n_out, chan_a_user_out2_n_out}, 2'b01);
        chk(chan_b_serial_out, 1'b0);
        apb(1'b0, 8'h80, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        chk(exp_q.size() == 0, 1'b1);
        $display("test irq and regs done");
        finish_test();
    end
endmodule : tb_uart_channel_modem_rs485_dir
